// file: src/i2ssp_pkg.sv
// Purpose: shared constants for the stereo serial audio port
// Assumes: one 125 MHz system clock
// Notes: pin inputs are synchronous to ref_clk
package i2ssp_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned FRAME_RATE_HZ = 48000;
  localparam int unsigned FRAME_SHORT = 32;
  localparam int unsigned FRAME_LONG = 50;
  localparam int unsigned SLAVE_MAX_HZ = 3072000;
  localparam int unsigned SLOT_W = 6;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_N_SHORT = 16'h00c0;
  localparam logic [DIV_W-1:0] DIV_M_SHORT = 16'h3d09;
  localparam logic [DIV_W-1:0] DIV_N_LONG = 16'h0078;
  localparam logic [DIV_W-1:0] DIV_M_LONG = 16'h1869;
  localparam logic [DIV_W-1:0] ACC_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
endpackage

// file: src/i2ssp_edge_if.sv
// Purpose: carries bit clock edge events from the divider to the port
// Assumes: single clock domain
// Notes: edge strobes are one-cycle pulses
`timescale 1ns/1ps
interface i2ssp_edge_if;
  logic riseEn;
  logic fallEn;
  logic sckLevel;
  modport src (output riseEn, output fallEn, output sckLevel);
  modport dst (input riseEn, input fallEn, input sckLevel);
endinterface

// file: src/i2ssp_frac_div.sv
// Purpose: fractional N/M divider producing bit clock edge strobes
// Assumes: divN below divM/2 for a duty near one half
// Notes: toggles a level each accumulator wrap
`timescale 1ns/1ps
module i2ssp_frac_div
  import i2ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [DIV_W-1:0] divN,
  input wire logic [DIV_W-1:0] divM,
  i2ssp_edge_if.src edges
);
  logic [DIV_W:0] acc_ff, nxt_acc;
  logic sck_ff, nxt_sck;
  logic wrap;
  logic [DIV_W:0] sum;

  //////////////////////////////////////////////////////////////////////
  // accumulator adds 2N per cycle, toggling each wrap past M
  always_comb begin
    sum = acc_ff + {divN, 1'b0};
    wrap = enable && (sum >= {1'b0, divM});
    nxt_acc = acc_ff;
    nxt_sck = sck_ff;
    if (!enable) begin
      nxt_acc = '0;
      nxt_sck = 1'b0;
    end else if (wrap) begin
      nxt_acc = sum - {1'b0, divM};
      nxt_sck = ~sck_ff;
    end else begin
      nxt_acc = sum;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= '0;
      sck_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      sck_ff <= nxt_sck;
    end
  end

  assign edges.riseEn = wrap && !sck_ff;
  assign edges.fallEn = wrap && sck_ff;
  assign edges.sckLevel = sck_ff;
endmodule

// file: src/i2ssp_port.sv
// Purpose: two-channel serial audio port, master or slave
// Assumes: slave bit clock far slower than ref_clk
// Notes: word select low is left, high is right
// Notes on behaviour
// - master drives bit clock and word select; slave takes both as inputs
// - serial data output is always driven, in both roles
// - each channel word is 16 bits, most significant bit first
// - words are left-justified in their channel slot
// - msb appears one bit clock after word select change, on falling edges
// - left on word select low, right on word select high
// - master makes 48 kHz frames of 32 or 50 bit clocks
// - master bit clock comes from an N/M fractional divider
// - slave accepts any bit clock up to 3.072 MHz
// - master bit clock high and low each at least 0.35 period
`timescale 1ns/1ps
module i2ssp_port
  import i2ssp_pkg::*;
#(
  parameter int unsigned WORD_W = WORD_BITS
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic masterMode,
  input wire logic longFrame,
  input wire logic [DIV_W-1:0] divN,
  input wire logic [DIV_W-1:0] divM,
  input wire logic [WORD_W-1:0] txLeft,
  input wire logic [WORD_W-1:0] txRight,
  output logic txTake,
  output logic [WORD_W-1:0] rxLeft,
  output logic [WORD_W-1:0] rxRight,
  output logic rxValid,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe_n,
  input wire logic wsIn,
  output logic wsOut,
  output logic wsOe_n,
  output logic sdo,
  input wire logic sdi
);
  typedef enum logic {I2SSP_LEFT, I2SSP_RIGHT} i2ssp_chan_e;

  i2ssp_edge_if edges ();

  logic sckPrev_ff, nxt_sckPrev;
  logic wsPrev_ff, nxt_wsPrev;
  logic ws_ff, nxt_ws;
  logic [SLOT_W-1:0] bitCnt_ff, nxt_bitCnt;
  logic [WORD_W-1:0] shTx_ff, nxt_shTx;
  logic [WORD_W-1:0] shRx_ff, nxt_shRx;
  logic [WORD_W-1:0] holdRight_ff, nxt_holdRight;
  logic [WORD_W-1:0] rxLeft_ff, nxt_rxLeft;
  logic [WORD_W-1:0] rxRight_ff, nxt_rxRight;
  logic [SLOT_W-1:0] rxCnt_ff, nxt_rxCnt;
  logic sdo_ff, nxt_sdo;
  logic rxValid_ff, nxt_rxValid;
  logic txTake_ff, nxt_txTake;
  logic [SLOT_W-1:0] halfLen;
  logic rise, fall, wsNow, wsChange, rxDone;
  i2ssp_chan_e chan;

  //////////////////////////////////////////////////////////////////////
  // bit clock source: divider in master, pin edges in slave
  i2ssp_frac_div u_div (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(masterMode),
    .divN(divN),
    .divM(divM),
    .edges(edges)
  );

  assign halfLen = longFrame ? SLOT_W'(FRAME_LONG / 2) : SLOT_W'(FRAME_SHORT / 2);

  always_comb begin
    nxt_sckPrev = sckIn;
    if (masterMode) begin
      rise = edges.riseEn;
      fall = edges.fallEn;
    end else begin
      rise = sckIn && !sckPrev_ff;
      fall = !sckIn && sckPrev_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // master word select generation on falling edges
  always_comb begin
    nxt_ws = ws_ff;
    nxt_bitCnt = bitCnt_ff;
    if (masterMode && fall) begin
      if (bitCnt_ff == halfLen - SLOT_W'(1)) begin
        nxt_bitCnt = '0;
        nxt_ws = ~ws_ff;
      end else begin
        nxt_bitCnt = bitCnt_ff + SLOT_W'(1);
      end
    end
  end

  assign wsNow = masterMode ? ws_ff : wsIn;
  assign chan = wsNow ? I2SSP_RIGHT : I2SSP_LEFT;

  //////////////////////////////////////////////////////////////////////
  // transmit: ws change seen at a rise loads the word for next fall
  always_comb begin
    nxt_wsPrev = wsPrev_ff;
    nxt_shTx = shTx_ff;
    nxt_sdo = sdo_ff;
    nxt_holdRight = holdRight_ff;
    nxt_txTake = 1'b0;
    wsChange = 1'b0;
    if (rise) begin
      nxt_wsPrev = wsNow;
      wsChange = (wsNow != wsPrev_ff);
    end
    if (rise && wsChange) begin
      if (chan == I2SSP_LEFT) begin
        nxt_shTx = txLeft;
        nxt_holdRight = txRight;
        nxt_txTake = 1'b1;
      end else begin
        nxt_shTx = holdRight_ff;
      end
    end else if (fall) begin
      nxt_sdo = shTx_ff[WORD_W-1];
      nxt_shTx = {shTx_ff[WORD_W-2:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive: sample sdi on rising edges, msb first
  // in 32-clock frames the lsb lands on the rise that shows the ws change
  always_comb begin
    nxt_shRx = shRx_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxLeft = rxLeft_ff;
    nxt_rxRight = rxRight_ff;
    nxt_rxValid = 1'b0;
    rxDone = 1'b0;
    if (rise) begin
      if (rxCnt_ff < SLOT_W'(WORD_W)) begin
        nxt_shRx = {shRx_ff[WORD_W-2:0], sdi};
        nxt_rxCnt = rxCnt_ff + SLOT_W'(1);
        rxDone = (rxCnt_ff == SLOT_W'(WORD_W - 1));
      end
      if (wsChange) begin
        nxt_rxCnt = '0;
      end
    end
    if (rxDone) begin
      if (wsPrev_ff) begin
        nxt_rxRight = {shRx_ff[WORD_W-2:0], sdi};
        nxt_rxValid = 1'b1;
      end else begin
        nxt_rxLeft = {shRx_ff[WORD_W-2:0], sdi};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // edge detect registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sckPrev_ff <= 1'b0;
    end else begin
      sckPrev_ff <= nxt_sckPrev;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // word select registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ws_ff <= 1'b0;
      bitCnt_ff <= '0;
    end else begin
      ws_ff <= nxt_ws;
      bitCnt_ff <= nxt_bitCnt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wsPrev_ff <= 1'b0;
      shTx_ff <= WORD_RESET;
      holdRight_ff <= WORD_RESET;
      sdo_ff <= 1'b0;
      txTake_ff <= 1'b0;
    end else begin
      wsPrev_ff <= nxt_wsPrev;
      shTx_ff <= nxt_shTx;
      holdRight_ff <= nxt_holdRight;
      sdo_ff <= nxt_sdo;
      txTake_ff <= nxt_txTake;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shRx_ff <= WORD_RESET;
      rxLeft_ff <= WORD_RESET;
      rxRight_ff <= WORD_RESET;
      rxCnt_ff <= SLOT_W'(WORD_W);
      rxValid_ff <= 1'b0;
    end else begin
      shRx_ff <= nxt_shRx;
      rxLeft_ff <= nxt_rxLeft;
      rxRight_ff <= nxt_rxRight;
      rxCnt_ff <= nxt_rxCnt;
      rxValid_ff <= nxt_rxValid;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pins
  assign sckOut = edges.sckLevel;
  assign sckOe_n = ~masterMode;
  assign wsOut = ws_ff;
  assign wsOe_n = ~masterMode;
  assign sdo = sdo_ff;
  assign rxLeft = rxLeft_ff;
  assign rxRight = rxRight_ff;
  assign rxValid = rxValid_ff;
  assign txTake = txTake_ff;
endmodule

// file: tb/i2ssp_codec_model.sv
// Purpose: far-side codec model
// Assumes: pins move on ref_clk
// Notes: makes sck and ws when the port is slave
`timescale 1ns/1ps
module i2ssp_codec_model
  import i2ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic masterMode,
  input wire logic sckOut,
  input wire logic wsOut,
  input wire logic sdo,
  input wire logic [31:0] inW,
  output logic sckIn,
  output logic wsIn,
  output logic sdi,
  output logic [31:0] got,
  output logic gotValid
);
  logic sck, ws, sckQ, wsR, load;
  logic [15:0] sh;
  logic [31:0] acc;
  int hc, bc, n;
  assign sck = masterMode ? sckOut : sckIn;
  assign ws = masterMode ? wsOut : wsIn;
  initial {sckIn, wsIn, sdi, gotValid, sckQ, wsR, load, hc, bc, n} = '0;
  ////////////////
  always @(posedge ref_clk) begin
    gotValid <= 1'b0;
    sckQ <= sck;
    hc <= (hc == 20) ? 0 : hc + 1;
    if (!masterMode && hc == 20) begin
      sckIn <= !sckIn;
      if (sckIn) bc <= (bc == 19) ? 0 : bc + 1;
      if (sckIn && bc == 19) wsIn <= !wsIn;
    end
    if (sck && !sckQ) begin
      if (n < 16) acc = {acc[30:0], sdo};
      n <= (ws != wsR) ? 0 : n + 1;
      load <= ws != wsR;
      gotValid <= ws != wsR && !ws;
      if (ws != wsR && !ws) got <= acc;
      wsR <= ws;
    end
    if (!sck && sckQ) begin
      sh <= load ? (ws ? inW[15:0] : inW[31:16]) : sh << 1;
      sdi <= load ? (ws ? inW[15] : inW[31]) : sh[14];
    end
  end
endmodule

// file: tb/i2ssp_port_sva.sv
// Purpose: port assertions
// Assumes: one clock domain
// Notes: bound to the port module
`timescale 1ns/1ps
module i2ssp_port_sva
  import i2ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic masterMode,
  input wire logic longFrame,
  input wire logic sckOut,
  input wire logic sckOe_n,
  input wire logic wsOut,
  input wire logic wsOe_n,
  input wire logic sdo,
  input wire logic txTake
);
  logic [7:0] phCnt_ff, riseCnt_ff;
  logic wsSeen_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phCnt_ff <= 8'h00;
      riseCnt_ff <= 8'h00;
      wsSeen_ff <= 1'b0;
    end else begin
      phCnt_ff <= $changed(sckOut) ? 8'h01 : phCnt_ff + 8'h01;
      riseCnt_ff <= $changed(wsOut) ? 8'h00 : riseCnt_ff + 8'($rose(sckOut));
      wsSeen_ff <= wsSeen_ff | $changed(wsOut);
    end
  end
  ////////////////
  property p_oe; sckOe_n == !masterMode && wsOe_n == !masterMode; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_edge; masterMode && $changed(sdo) |-> !sckOut; endproperty
  a_edge: assert property (p_edge) else $error("data moved in high phase");
  property p_wsedge; masterMode && $changed(wsOut) |-> !sckOut; endproperty
  a_wsedge: assert property (p_wsedge) else $error("ws moved in high phase");
  property p_duty; masterMode && $changed(sckOut) |-> phCnt_ff >= (longFrame ? 8'h13 : 8'h1d); endproperty
  a_duty: assert property (p_duty) else $error("clock phase short");
  property p_rate; masterMode && wsSeen_ff && $changed(sckOut) |-> phCnt_ff <= (longFrame ? 8'h1b : 8'h29); endproperty
  a_rate: assert property (p_rate) else $error("clock phase long");
  property p_frame; masterMode && wsSeen_ff && $changed(wsOut) |-> riseCnt_ff == (longFrame ? 8'h19 : 8'h10); endproperty
  a_frame: assert property (p_frame) else $error("slot length wrong");
  property p_zero; masterMode && sckOut && riseCnt_ff >= 8'h12 |-> !sdo; endproperty
  a_zero: assert property (p_zero) else $error("pad bit not zero");
  property p_take; masterMode && txTake |-> !wsOut ##1 !txTake; endproperty
  a_take: assert property (p_take) else $error("take outside left slot");
endmodule
bind i2ssp_port i2ssp_port_sva i_sva (.ref_clk, .reset_n, .masterMode, .longFrame, .sckOut, .sckOe_n, .wsOut,
  .wsOe_n, .sdo, .txTake);

// file: tb/tb_top.sv
// Purpose: self-checking bench for the audio port
// Assumes: codec model on the pins
// Notes: master short, master long, then slave
`timescale 1ns/1ps
module tb_top
  import i2ssp_pkg::*;
;
  logic ref_clk = 0, reset_n = 0, masterMode = 1, longFrame = 0, armed = 0;
  logic sckIn, wsIn, sdi, gotValid, txTake, rxValid, sckOut, sckOe_n, wsOut, wsOe_n, sdo;
  logic [DIV_W-1:0] divN = DIV_N_SHORT, divM = DIV_M_SHORT;
  logic [15:0] txLeft = 0, txRight = 0, rxLeft, rxRight;
  logic [31:0] inW = 0, got, txQ[$];
  int bad_count = 0, num_checks = 0, nGot, nRx;
  i2ssp_port i_dut (.ref_clk, .reset_n, .masterMode, .longFrame, .divN, .divM, .txLeft, .txRight, .txTake,
    .rxLeft, .rxRight, .rxValid, .sckIn, .sckOut, .sckOe_n, .wsIn, .wsOut, .wsOe_n, .sdo, .sdi);
  i2ssp_codec_model i_codec (.ref_clk, .masterMode, .sckOut, .wsOut, .sdo, .inW, .sckIn, .wsIn, .sdi, .got,
    .gotValid);
  initial forever #4 ref_clk = ~ref_clk;
  ////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hold(input bit forTake);
    for (int i = 0; i < 12000; i++) begin
      @(posedge ref_clk);
      if (forTake ? txTake === 1'b1 : nGot > 2 && nRx > 2) return;
    end
    bad_count++;
    wrap_up();
  endtask
  task automatic phase(input logic m, input logic lf);
    reset_n <= 1'b0;
    masterMode <= m;
    longFrame <= lf;
    {divN, divM} <= lf ? {DIV_N_LONG, DIV_M_LONG} : {DIV_N_SHORT, DIV_M_SHORT};
    inW <= $urandom;
    repeat (2) @(posedge ref_clk);
    txQ.delete();
    reset_n <= 1'b1;
    hold(1'b1);
    repeat (10) @(posedge ref_clk);
    nGot = 0;
    nRx = 0;
    armed = 1;
    hold(1'b0);
    #1;
    chk(32'({sckOe_n, wsOe_n}), 32'({!m, !m}));
    chk(32'(sdo === 1'b0 || sdo === 1'b1), 32'h1);
    armed = 0;
    @(posedge ref_clk);
  endtask
  ////////////////
  always @(posedge ref_clk) begin
    if (txTake === 1'b1) begin
      txQ.push_back({txLeft, txRight});
      {txLeft, txRight} <= $urandom;
    end
  end
  always @(posedge ref_clk) begin
    if (armed && gotValid === 1'b1) begin
      chk(got, txQ.pop_front());
      nGot++;
    end
    if (armed && rxValid === 1'b1) begin
      chk({rxLeft, rxRight}, inW);
      nRx++;
    end
  end
  initial begin
    void'($urandom(32'h0eca45c9));
    phase(1'b1, 1'b0);
    phase(1'b1, 1'b1);
    phase(1'b0, 1'b0);
    wrap_up();
  end
endmodule
